//--- bench/core_model.sv
`timescale 1ns/100ps
// ****************************************
// Core side: sleep pulses and held wake lines
// ****************************************
module core_model (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_sleep_req,
  input  wire logic i_wake_req,
  input  wire logic i_use_event,
  input  wire logic i_resume,
  output logic      o_sleep_exec,
  output logic      o_interrupt,
  output logic      o_wake_event
);
  // Wake lines are held until the block answers, as a real source would be.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sleep_exec <= 1'b0;
      o_interrupt  <= 1'b0;
      o_wake_event <= 1'b0;
    end else begin
      o_sleep_exec <= i_sleep_req;
      if (i_resume) begin
        o_interrupt  <= 1'b0;
        o_wake_event <= 1'b0;
      end else if (i_wake_req) begin
        o_interrupt  <= !i_use_event;
        o_wake_event <= i_use_event;
      end
    end
  end
endmodule

//--- bench/pmc_checker.sv
`timescale 1ns/100ps
// ****************************************
// Power-mode protocol checker
// ****************************************
module pmc_checker
  import pmc_pkg::*;
#(
  parameter int LAT_ALL = 500
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_sleep_exec,
  input  wire logic        i_interrupt,
  input  wire logic        i_wake_event,
  input  wire logic        o_core_halt,
  input  wire logic        o_resume,
  input  wire logic        o_pipeline_flush,
  input  wire logic        o_boot_start,
  input  wire logic [23:0] o_boot_addr,
  input  clk_gate_t        o_clk_gate,
  input  wire logic        o_periph_tick,
  input  wire logic        o_clock_output_pin,
  input  pll_ctl_t         o_pll_ctl
);
  localparam int ALL_D = LAT_ALL + 1;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire logic run_sleep = i_sleep_exec && !o_core_halt;
  wire logic [2:0] mode = {o_pll_ctl.power_down_all_bit_all, o_pll_ctl.stop_all, o_pll_ctl.stop_core};

  idle_entry_a: assert property (run_sleep && mode == 3'b000 |=> o_core_halt && o_clk_gate == 3'b111) else $error("idle gating wrong");
  core_entry_a: assert property (run_sleep && mode == 3'b001 |=> o_clk_gate == 3'b110) else $error("core power-down gating wrong");
  cp_entry_a: assert property (run_sleep && mode[2:1] == 2'b01 |=> o_clk_gate == 3'b100 && o_pipeline_flush) else $error("core/periph power-down wrong");
  all_entry_a: assert property (run_sleep && mode[2] |=> o_clk_gate == 3'b000 && o_pipeline_flush) else $error("power-down all wrong");
  idle_wake_a: assert property (o_core_halt && o_clk_gate == 3'b111 && i_interrupt |-> !o_resume[*3] ##1 o_resume) else $error("idle wake latency wrong");
  core_wake_a: assert property (o_core_halt && o_clk_gate == 3'b110 && i_interrupt && !$past(i_interrupt) |-> !o_resume[*3] ##1 o_resume) else $error("core wake latency wrong");
  cp_wake_a: assert property (o_core_halt && o_clk_gate == 3'b100 && i_wake_event |-> !o_resume[*6] ##1 o_resume) else $error("core/periph wake latency wrong");
  all_wake_a: assert property (o_clk_gate == 3'b000 && i_interrupt |-> ##ALL_D o_resume) else $error("power-down all wake latency wrong");
  clk_pin_a: assert property (o_clock_output_pin == o_periph_tick) else $error("clock pin differs from peripheral clock");
  half_tick_a: assert property (o_pll_ctl.half_sel && $past(o_pll_ctl.half_sel) && o_clk_gate.periph && $past(o_clk_gate.periph) |-> o_periph_tick != $past(o_periph_tick)) else $error("half rate tick wrong");
  full_tick_a: assert property (!o_pll_ctl.half_sel && !$past(o_pll_ctl.half_sel) && o_clk_gate.periph && $past(o_clk_gate.periph) |-> o_periph_tick) else $error("full rate tick wrong");
  boot_addr_a: assert property (o_boot_start |=> o_boot_addr == 24'hFF0000) else $error("boot address wrong");
endmodule

bind power_mode_clock_reset_ctrl pmc_checker #(.LAT_ALL(LAT_ALL)) i_chk (.i_clock, .i_rst_n,
  .i_sleep_exec, .i_interrupt, .i_wake_event, .o_core_halt, .o_resume, .o_pipeline_flush,
  .o_boot_start, .o_boot_addr, .o_clk_gate, .o_periph_tick, .o_clock_output_pin, .o_pll_ctl);

//--- bench/tb_top.sv
`timescale 1ns/100ps
// ****************************************
// Testbench
// ****************************************
module tb_top;
  import pmc_pkg::*;
  logic i_clock, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [6:0]  i_multiplier_select_pins;
  logic i_bypass_pin, i_divide_frequency_pin, i_boot_enable, i_bus_request;
  logic i_sleep_exec, i_interrupt, i_wake_event, o_core_halt, o_resume, o_pipeline_flush;
  logic o_master_reset, o_boot_start, o_periph_tick, o_clock_output_pin;
  logic [23:0] o_boot_addr;
  clk_gate_t   o_clk_gate;
  pll_ctl_t    o_pll_ctl;
  logic sleep_req, wake_req, use_event, err, wk_prev;
  logic [31:0] lat, cfg, expq[$];
  int seed = 65, n_mismatch = 0, num_checks = 0, i, k;
  logic [2:0] m_ctl [4] = '{3'b000, 3'b001, 3'b011, 3'b111};
  logic [31:0] m_st [4] = '{32'hF3, 32'hE4, 32'hC5, 32'h86};
  logic [31:0] m_lat [4] = '{32'h3, 32'h3, 32'h6, 32'h9};

  power_mode_clock_reset_ctrl #(.LAT_ALL(8)) i_dut (.*);
  core_model i_core (.i_clock, .i_rst_n, .i_sleep_req(sleep_req), .i_wake_req(wake_req),
    .i_use_event(use_event), .i_resume(o_resume), .o_sleep_exec(i_sleep_exec),
    .o_interrupt(i_interrupt), .o_wake_event(i_wake_event));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel    <= 1'b1;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    @(posedge i_clock);
    while (o_pready !== 1'b1) @(posedge i_clock);
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // Results are compared in order of appearance against the notes of the driver.
  always @(posedge i_clock) begin
    if ((i_interrupt | i_wake_event) && !wk_prev) lat = 0;
    else lat = lat + 1;
    wk_prev = i_interrupt | i_wake_event;
    if (i_psel && i_penable && o_pready && !i_pwrite)
      check(o_prdata, expq.size() ? expq.pop_front() : 32'hDEAD);
    if (o_resume === 1'b1)
      check(lat, expq.size() ? expq.pop_front() : 32'hDEAD);
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_bus_request} = '0;
    {sleep_req, wake_req, use_event, wk_prev, lat} = '0;
    i_rst_n = 1'b0;
    i_boot_enable = 1'b1;
    cfg = $random(seed);
    {i_divide_frequency_pin, i_bypass_pin, i_multiplier_select_pins} = cfg[8:0];
    repeat (20) @(posedge i_clock);
    check({31'h0, o_master_reset}, 32'h1);
    i_rst_n <= 1'b1;
    for (i = 0; i < 50 && o_core_halt !== 1'b0; i++) @(posedge i_clock);
    check({7'h0, o_core_halt, o_boot_addr}, 32'h00FF0000);
    expq.push_back({23'h0, cfg[8:0]});
    apb(1'b0, 12'h000, 32'h0);
    expq.push_back(32'h00FF0000);
    apb(1'b0, 12'h008, 32'h0);
    expq.push_back(32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test reset and map done");
    cfg = $random(seed);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 12'h000, {19'h0, m_ctl[k], k[0], cfg[8:0]});
      expq.push_back({19'h0, m_ctl[k], k[0], cfg[8:0]});
      apb(1'b0, 12'h000, 32'h0);
      @(posedge i_clock);
      sleep_req <= 1'b1;
      @(posedge i_clock);
      sleep_req <= 1'b0;
      repeat (3) @(posedge i_clock);
      expq.push_back(m_st[k]);
      apb(1'b0, 12'h004, 32'h0);
      expq.push_back(m_lat[k]);
      use_event <= (k == 2);
      wake_req  <= 1'b1;
      @(posedge i_clock);
      wake_req  <= 1'b0;
      for (i = 0; i < 1000 && o_resume !== 1'b1; i++) @(posedge i_clock);
      check({31'h0, o_resume}, 32'h1);
      repeat (2) @(posedge i_clock);
      $display("test mode %0d done", k);
    end
    i_rst_n <= 1'b0;
    i_bus_request <= 1'b1;
    i_boot_enable <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (10) @(posedge i_clock);
    check({31'h0, o_core_halt}, 32'h1);
    i_bus_request <= 1'b0;
    for (i = 0; i < 50 && o_core_halt !== 1'b0; i++) @(posedge i_clock);
    check({7'h0, o_core_halt, o_boot_addr}, 32'h0);
    $display("test bus request hold done");
    report_and_stop();
  end
endmodule

//--- verilog/latency_timer.sv
`timescale 1ns/100ps
`include "pmc_regs.svh"

module latency_timer #(
  parameter int W = `PMC_TIMER_W
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  // Status
  output logic              o_busy,
  output logic              o_done
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         busy_q;
  logic         busy_d;

  // Done marks the last cycle of the wait; the caller acts at the next edge.
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (i_load) begin
      cnt_d  = i_count;
      busy_d = 1'b1;
    end else if (busy_q) begin
      cnt_d = cnt_q - W'(1);
      if (cnt_q == W'(1)) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = busy_q && (cnt_q == W'(1));

endmodule

//--- verilog/pmc_pkg.sv
package pmc_pkg;

  typedef enum logic [3:0] {
    ST_INIT,
    ST_BOOT_WAIT,
    ST_RUN,
    ST_IDLE,
    ST_PD_CORE,
    ST_PD_CORE_PERIPH,
    ST_PD_ALL,
    ST_WAKE
  } pmc_state_t;

  typedef struct packed {
    logic       power_down_all_bit_all;
    logic       stop_all;
    logic       stop_core;
    logic       half_sel;
    logic       divide;
    logic       bypass;
    logic [6:0] mult;
  } pll_ctl_t;

  typedef struct packed {
    logic pll;
    logic periph;
    logic core;
  } clk_gate_t;

endpackage

//--- verilog/pmc_regs.svh
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PMC_PLL_CTL_OFFSET   12'h000
`define PMC_STATUS_OFFSET    12'h004
`define PMC_BOOT_ADDR_OFFSET 12'h008

// ****************************************************************
// Field positions in the PLL control register
// ****************************************************************
`define PMC_MULT_LSB         0
`define PMC_MULT_W           7
`define PMC_BYPASS_BIT       7
`define PMC_DIVIDE_BIT       8
`define PMC_HALF_SEL_BIT     9
`define PMC_STOP_CORE_BIT    10
`define PMC_STOP_ALL_BIT     11
`define PMC_POWER_DOWN_ALL_BIT_ALL_BIT     12

// ****************************************************************
// Field positions in the status register
// ****************************************************************
`define PMC_ST_STATE_LSB     0
`define PMC_ST_CORE_BIT      4
`define PMC_ST_PERIPH_BIT    5
`define PMC_ST_PLL_BIT       6
`define PMC_ST_BOOTED_BIT    7

// ****************************************************************
// Reset values, timing counts in core clock cycles, and the timer width in bits
// ****************************************************************
`define PMC_PLL_CTL_RESET    13'h0000
`define PMC_BOOT_ADDR        24'hFF0000
`define PMC_LAT_IDLE         2
`define PMC_LAT_CORE         2
`define PMC_LAT_CORE_PERIPH  5
`define PMC_LAT_ALL          500
`define PMC_TIMER_W          10

`endif

//--- verilog/power_mode_clock_reset_ctrl.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "pmc_regs.svh"

// Summary of operation
// - Idle stops execution, keeps pipeline, core and peripheral clocks run.
// - Interrupt in Idle resumes after two cycles at the next instruction.
// - Core power-down stops core clock, keeps pipeline, PLL, peripheral clock.
// - Sleep with stop-core set and other two clear enters core power-down.
// - Interrupt in core power-down resumes after two cycles.
// - Core/peripheral power-down stops both clocks, PLL runs, pipeline lost.
// - Sleep with stop-all set and power-down-all clear enters that mode.
// - Wake event in core/peripheral power-down resumes after five cycles.
// - Power-down all stops core, peripheral clock and PLL; pipeline lost.
// - Sleep with power-down-all set enters power-down all.
// - Interrupt in power-down all resumes after 500 cycles of PLL settling.
// - Peripheral clock equals core clock or half of it, per select bit.
// - Peripheral clock is driven onto the clock output pin.
// - PLL factor taken from pins at reset, changeable by software later.
// - Master reset empties stacks, masks interrupts, restores register defaults.
// - Reset release without bus request and with boot set jumps to boot ROM.
module power_mode_clock_reset_ctrl
  import pmc_pkg::*;
#(
  parameter int LAT_IDLE        = `PMC_LAT_IDLE,
  parameter int LAT_CORE        = `PMC_LAT_CORE,
  parameter int LAT_CORE_PERIPH = `PMC_LAT_CORE_PERIPH,
  parameter int LAT_ALL         = `PMC_LAT_ALL
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Reset-time straps
  input  wire logic [6:0]  i_multiplier_select_pins,
  input  wire logic        i_bypass_pin,
  input  wire logic        i_divide_frequency_pin,
  input  wire logic        i_boot_enable,
  input  wire logic        i_bus_request,
  // Core handshake
  input  wire logic        i_sleep_exec,
  input  wire logic        i_interrupt,
  input  wire logic        i_wake_event,
  output logic             o_core_halt,
  output logic             o_resume,
  output logic             o_pipeline_flush,
  output logic             o_master_reset,
  output logic             o_boot_start,
  output logic [23:0]      o_boot_addr,
  // Clock control
  output clk_gate_t        o_clk_gate,
  output logic             o_periph_tick,
  output logic             o_clock_output_pin,
  output pll_ctl_t         o_pll_ctl
);

  localparam int TW = `PMC_TIMER_W;

  // ****************************************************************
  // State
  // ****************************************************************
  pmc_state_t  state_q;
  pmc_state_t  state_d;
  pll_ctl_t    pll_q;
  pll_ctl_t    pll_d;
  clk_gate_t   gate_q;
  clk_gate_t   gate_d;
  logic        booted_q;
  logic        booted_d;
  logic        resume_q;
  logic        resume_d;
  logic        flush_q;
  logic        flush_d;
  logic        boot_q;
  logic        boot_d;
  logic [23:0] boot_addr_q;
  logic [23:0] boot_addr_d;
  logic        div_q;
  logic        div_d;
  logic        tick_q;
  logic        tick_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        t_load;
  logic [TW-1:0] t_count;
  logic        t_busy;
  logic        t_done;
  logic        setup;
  logic        wr_en;
  logic        addr_ok;

  latency_timer #(
    .W (TW)
  ) u_timer (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_load  (t_load),
    .i_count (t_count),
    .o_busy  (t_busy),
    .o_done  (t_done)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign setup   = i_psel && !i_penable;
  assign wr_en   = i_psel && i_penable && i_pwrite;
  assign addr_ok = (i_paddr == `PMC_PLL_CTL_OFFSET) ||
                   (i_paddr == `PMC_STATUS_OFFSET) ||
                   (i_paddr == `PMC_BOOT_ADDR_OFFSET);

  // Zero wait states: read data is captured in the setup cycle.
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  always_comb begin
    rdata_d = rdata_q;
    if (setup) begin
      rdata_d = '0;
      unique case (i_paddr)
        `PMC_PLL_CTL_OFFSET: begin
          rdata_d[12:0] = pll_q;
        end
        `PMC_STATUS_OFFSET: begin
          rdata_d[`PMC_ST_STATE_LSB +: 4] = state_q;
          rdata_d[`PMC_ST_CORE_BIT]       = gate_q.core;
          rdata_d[`PMC_ST_PERIPH_BIT]     = gate_q.periph;
          rdata_d[`PMC_ST_PLL_BIT]        = gate_q.pll;
          rdata_d[`PMC_ST_BOOTED_BIT]     = booted_q;
        end
        `PMC_BOOT_ADDR_OFFSET: begin
          rdata_d[23:0] = `PMC_BOOT_ADDR;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Power mode sequencer
  // ****************************************************************
  always_comb begin
    state_d     = state_q;
    pll_d       = pll_q;
    booted_d    = booted_q;
    resume_d    = 1'b0;
    flush_d     = 1'b0;
    boot_d      = 1'b0;
    boot_addr_d = boot_addr_q;
    t_load      = 1'b0;
    t_count     = '0;
    if (wr_en && (i_paddr == `PMC_PLL_CTL_OFFSET) && (state_q != ST_INIT)) begin
      pll_d = pll_ctl_t'(i_pwdata[12:0]);
    end
    unique case (state_q)
      ST_INIT: begin
        // Straps are caught on the first edge after reset release.
        pll_d          = `PMC_PLL_CTL_RESET;
        pll_d.mult     = i_multiplier_select_pins;
        pll_d.bypass   = i_bypass_pin;
        pll_d.divide   = i_divide_frequency_pin;
        state_d        = ST_BOOT_WAIT;
      end
      ST_BOOT_WAIT: begin
        // A pending external bus request delays the hand-off until it drops.
        if (!i_bus_request) begin
          state_d = ST_RUN;
          if (i_boot_enable) begin
            boot_d      = 1'b1;
            boot_addr_d = `PMC_BOOT_ADDR;
            booted_d    = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (i_sleep_exec) begin
          if (pll_q.power_down_all_bit_all) begin
            state_d = ST_PD_ALL;
            flush_d = 1'b1;
          end else if (pll_q.stop_all) begin
            state_d = ST_PD_CORE_PERIPH;
            flush_d = 1'b1;
          end else if (pll_q.stop_core) begin
            state_d = ST_PD_CORE;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (i_interrupt) begin
          t_load  = 1'b1;
          t_count = TW'(LAT_IDLE);
          state_d = ST_WAKE;
        end
      end
      ST_PD_CORE: begin
        if (i_interrupt) begin
          t_load  = 1'b1;
          t_count = TW'(LAT_CORE);
          state_d = ST_WAKE;
        end
      end
      ST_PD_CORE_PERIPH: begin
        if (i_wake_event || i_interrupt) begin
          t_load  = 1'b1;
          t_count = TW'(LAT_CORE_PERIPH);
          state_d = ST_WAKE;
        end
      end
      ST_PD_ALL: begin
        if (i_interrupt) begin
          t_load  = 1'b1;
          t_count = TW'(LAT_ALL);
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (t_done) begin
          resume_d = 1'b1;
          state_d  = ST_RUN;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  // ****************************************************************
  // Clock gating and peripheral clock divider
  // ****************************************************************
  always_comb begin
    gate_d = '{pll: 1'b1, periph: 1'b1, core: 1'b1};
    unique case (state_d)
      ST_PD_CORE: begin
        gate_d.core = 1'b0;
      end
      ST_PD_CORE_PERIPH: begin
        gate_d.core   = 1'b0;
        gate_d.periph = 1'b0;
      end
      ST_PD_ALL: begin
        gate_d = '{pll: 1'b0, periph: 1'b0, core: 1'b0};
      end
      ST_WAKE: begin
        // The PLL restarts at once; the core clock returns only on resume.
        gate_d.core = 1'b0;
      end
      default: begin
        gate_d = gate_d;
      end
    endcase
    // The divider phase is held while the peripheral clock is stopped.
    div_d  = gate_d.periph ? ~div_q : div_q;
    tick_d = gate_d.periph && (!pll_d.half_sel || div_q);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= ST_INIT;
      pll_q       <= `PMC_PLL_CTL_RESET;
      gate_q      <= '{pll: 1'b1, periph: 1'b0, core: 1'b0};
      booted_q    <= 1'b0;
      resume_q    <= 1'b0;
      flush_q     <= 1'b0;
      boot_q      <= 1'b0;
      boot_addr_q <= '0;
      div_q       <= 1'b0;
      tick_q      <= 1'b0;
      rdata_q     <= '0;
    end else begin
      state_q     <= state_d;
      pll_q       <= pll_d;
      gate_q      <= gate_d;
      booted_q    <= booted_d;
      resume_q    <= resume_d;
      flush_q     <= flush_d;
      boot_q      <= boot_d;
      boot_addr_q <= boot_addr_d;
      div_q       <= div_d;
      tick_q      <= tick_d;
      rdata_q     <= rdata_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_prdata           = rdata_q;
  assign o_pll_ctl          = pll_q;
  assign o_clk_gate         = gate_q;
  assign o_periph_tick      = tick_q;
  assign o_clock_output_pin = tick_q;
  assign o_resume           = resume_q;
  assign o_pipeline_flush   = flush_q;
  assign o_boot_start       = boot_q;
  assign o_boot_addr        = boot_addr_q;
  // Stacks empty and interrupts masked for as long as this is high.
  assign o_master_reset     = (state_q == ST_INIT);
  assign o_core_halt        = (state_q != ST_RUN);

endmodule
